//--- pkg/nhmac_regs.svh
// Purpose: Register offsets, field positions and reset values of the negative MAC unit
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Definitions only
`ifndef NHMAC_REGS_SVH
`define NHMAC_REGS_SVH

`define NHMAC_ADDR_W        5
`define NHMAC_OFF_CTRL      5'h00
`define NHMAC_OFF_SRC_A     5'h04
`define NHMAC_OFF_SRC_B     5'h08
`define NHMAC_OFF_DEST      5'h0C
`define NHMAC_OFF_FXEXC     5'h10
`define NHMAC_OFF_CRZ       5'h14
`define NHMAC_OFF_STATUS    5'h18

`define NHMAC_CTRL_START    0
`define NHMAC_CTRL_LOW      1
`define NHMAC_CTRL_SAT      2
`define NHMAC_CTRL_REC      3
`define NHMAC_CTRL_OVE      4

`define NHMAC_FX_SUMMARY    31
`define NHMAC_FX_EXCESS     30

`define NHMAC_CR_NEG        3
`define NHMAC_CR_POS        2
`define NHMAC_CR_ZERO       1
`define NHMAC_CR_SUMMARY    0

`define NHMAC_ST_BUSY       0
`define NHMAC_ST_DONE       1

`define NHMAC_RST_WORD      32'h0000_0000
`define NHMAC_RST_CR        4'h0
`define NHMAC_SAT_MAX       32'h7FFF_FFFF
`define NHMAC_SAT_MIN       32'h8000_0000

`define NHMAC_RESP_OKAY     2'h0
`define NHMAC_RESP_SLVERR   2'h2

`endif

//--- pkg/nhmac_pkg.sv
// Purpose: Types shared by the negative MAC unit
// Assumes: Constants come from nhmac_regs.svh
// Notes:   States use Gray codes along idle, calc, write
package nhmac_pkg;
    typedef enum logic [1:0] {
        NHMAC_IDLE  = 2'h0,
        NHMAC_CALC  = 2'h1,
        NHMAC_WRITE = 2'h3
    } nhmac_state_e;

    typedef logic [31:0] nhmac_word_t;
    typedef logic [32:0] nhmac_wide_t;
endpackage : nhmac_pkg

//--- verilog/nhmac_unit.sv
// Purpose: Negative multiply-accumulate halfword-to-word datapath behind AXI4-Lite
// Assumes: Big-endian bit 0 is our bit 31, so halfword 0:15 is [31:16], 16:31 is [15:0]
// Notes:   A start write runs calc then write; writes are ignored while busy
`timescale 1ns/100ps
`include "nhmac_regs.svh"

module nhmac_unit (
    input  wire logic                           ref_clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic [`NHMAC_ADDR_W-1:0]       s_axi_awaddr_i,
    input  wire logic                           s_axi_awvalid_i,
    output logic                                s_axi_awready_o,
    input  wire nhmac_pkg::nhmac_word_t         s_axi_wdata_i,
    input  wire logic [3:0]                     s_axi_wstrb_i,
    input  wire logic                           s_axi_wvalid_i,
    output logic                                s_axi_wready_o,
    output logic [1:0]                          s_axi_bresp_o,
    output logic                                s_axi_bvalid_o,
    input  wire logic                           s_axi_bready_i,
    input  wire logic [`NHMAC_ADDR_W-1:0]       s_axi_araddr_i,
    input  wire logic                           s_axi_arvalid_i,
    output logic                                s_axi_arready_o,
    output nhmac_pkg::nhmac_word_t              s_axi_rdata_o,
    output logic [1:0]                          s_axi_rresp_o,
    output logic                                s_axi_rvalid_o,
    input  wire logic                           s_axi_rready_i
);
    import nhmac_pkg::*;

    nhmac_state_e               state;
    logic                       aw_held;
    logic                       w_held;
    logic [`NHMAC_ADDR_W-1:0]   aw_addr;
    nhmac_word_t                w_data;
    logic [3:0]                 w_strb;
    nhmac_word_t                wmask;
    logic                       wr_fire;
    logic                       wr_ok;
    logic                       wr_mapped;
    logic                       start;
    nhmac_word_t                source_a;
    nhmac_word_t                source_b;
    nhmac_word_t                dest;
    nhmac_word_t                fixed_point_exception_reg;
    logic [3:0]                 condition_field_zero;
    logic                       op_low;
    logic                       op_sat;
    logic                       op_rec;
    logic                       op_ove;
    logic                       done;
    logic [15:0]                half_a;
    logic [15:0]                half_b;
    nhmac_word_t                product;
    nhmac_wide_t                inter;
    logic                       arith_excess_flag;
    nhmac_word_t                wb_value;
    logic                       next_summary;
    nhmac_word_t                rd_value;
    logic                       rd_mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels; address and data are taken in either order
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b0;
            aw_addr         <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b1;
            aw_addr         <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held         <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b0;
            w_data         <= `NHMAC_RST_WORD;
            w_strb         <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held         <= 1'b0;
        end else if (!w_held && !s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    assign wr_fire   = aw_held && w_held && !s_axi_bvalid_o;
    // Writes while busy would disturb operands mid-operation, so they are dropped
    assign wr_ok     = wr_fire && (state == NHMAC_IDLE);
    assign wr_mapped = (aw_addr <= `NHMAC_OFF_STATUS) && (aw_addr[1:0] == 2'h0);

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i +: 8] = {8{w_strb[i]}};
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `NHMAC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_mapped ? `NHMAC_RESP_OKAY : `NHMAC_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers
    assign start = wr_ok && (aw_addr == `NHMAC_OFF_CTRL) && w_strb[0]
                   && w_data[`NHMAC_CTRL_START];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            source_a <= `NHMAC_RST_WORD;
            source_b <= `NHMAC_RST_WORD;
        end else if (wr_ok && aw_addr == `NHMAC_OFF_SRC_A) begin
            source_a <= (source_a & ~wmask) | (w_data & wmask);
        end else if (wr_ok && aw_addr == `NHMAC_OFF_SRC_B) begin
            source_b <= (source_b & ~wmask) | (w_data & wmask);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            op_low <= 1'b0;
            op_sat <= 1'b0;
            op_rec <= 1'b0;
            op_ove <= 1'b0;
        end else if (wr_ok && aw_addr == `NHMAC_OFF_CTRL && w_strb[0]) begin
            op_low <= w_data[`NHMAC_CTRL_LOW];
            op_sat <= w_data[`NHMAC_CTRL_SAT];
            op_rec <= w_data[`NHMAC_CTRL_REC];
            op_ove <= w_data[`NHMAC_CTRL_OVE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer and datapath
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state <= NHMAC_IDLE;
        end else begin
            unique case (state)
                NHMAC_IDLE:  if (start) state <= NHMAC_CALC;
                NHMAC_CALC:  state <= NHMAC_WRITE;
                NHMAC_WRITE: state <= NHMAC_IDLE;
                default:     state <= NHMAC_IDLE;
            endcase
        end
    end

    assign half_a  = op_low ? source_a[15:0] : source_a[31:16];
    assign half_b  = op_low ? source_b[15:0] : source_b[31:16];
    // Operands widened first so the product is formed at full 32-bit width
    assign product = 32'($signed(half_a)) * 32'($signed(half_b));

    // Registered so the wide subtract and the clamp sit in separate cycles
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            inter <= '0;
        end else if (state == NHMAC_CALC) begin
            inter <= {dest[31], dest} - {product[31], product};
        end
    end

    assign arith_excess_flag = inter[32] ^ inter[31];
    always_comb begin
        if (op_sat && arith_excess_flag) begin
            wb_value = inter[32] ? `NHMAC_SAT_MIN : `NHMAC_SAT_MAX;
        end else begin
            wb_value = inter[31:0];
        end
    end
    assign next_summary = fixed_point_exception_reg[`NHMAC_FX_SUMMARY] | arith_excess_flag;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            dest <= `NHMAC_RST_WORD;
        end else if (state == NHMAC_WRITE) begin
            dest <= wb_value;
        end else if (wr_ok && aw_addr == `NHMAC_OFF_DEST) begin
            dest <= (dest & ~wmask) | (w_data & wmask);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fixed_point_exception_reg <= `NHMAC_RST_WORD;
        end else if (state == NHMAC_WRITE && op_ove) begin
            fixed_point_exception_reg[`NHMAC_FX_EXCESS]  <= arith_excess_flag;
            fixed_point_exception_reg[`NHMAC_FX_SUMMARY] <= next_summary;
        end else if (wr_ok && aw_addr == `NHMAC_OFF_FXEXC) begin
            fixed_point_exception_reg <= (fixed_point_exception_reg & ~wmask)
                                         | (w_data & wmask);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            condition_field_zero <= `NHMAC_RST_CR;
        end else if (state == NHMAC_WRITE && op_rec) begin
            condition_field_zero[`NHMAC_CR_NEG]  <= wb_value[31];
            condition_field_zero[`NHMAC_CR_POS]  <= !wb_value[31] && (wb_value != '0);
            condition_field_zero[`NHMAC_CR_ZERO] <= (wb_value == '0);
            // Summary copy includes this operation's excess when overflow is enabled
            condition_field_zero[`NHMAC_CR_SUMMARY] <= op_ove ? next_summary
                : fixed_point_exception_reg[`NHMAC_FX_SUMMARY];
        end else if (wr_ok && aw_addr == `NHMAC_OFF_CRZ && w_strb[0]) begin
            condition_field_zero <= w_data[3:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            done <= 1'b0;
        end else if (state == NHMAC_WRITE) begin
            done <= 1'b1;
        end else if (start) begin
            done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_comb begin
        rd_value  = `NHMAC_RST_WORD;
        rd_mapped = 1'b1;
        unique case (s_axi_araddr_i)
            `NHMAC_OFF_CTRL:   rd_value = {27'h0, op_ove, op_rec, op_sat, op_low, 1'b0};
            `NHMAC_OFF_SRC_A:  rd_value = source_a;
            `NHMAC_OFF_SRC_B:  rd_value = source_b;
            `NHMAC_OFF_DEST:   rd_value = dest;
            `NHMAC_OFF_FXEXC:  rd_value = fixed_point_exception_reg;
            `NHMAC_OFF_CRZ:    rd_value = {28'h0, condition_field_zero};
            `NHMAC_OFF_STATUS: rd_value = {30'h0, done, state != NHMAC_IDLE};
            default:           rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= `NHMAC_RST_WORD;
            s_axi_rresp_o   <= `NHMAC_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_value;
            s_axi_rresp_o   <= rd_mapped ? `NHMAC_RESP_OKAY : `NHMAC_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
        end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    nhmac_wide_t exp_hi;
    nhmac_wide_t exp_lo;
    assign exp_hi = {dest[31], dest}
        - (33'($signed(source_a[31:16])) * 33'($signed(source_b[31:16])));
    assign exp_lo = {dest[31], dest}
        - (33'($signed(source_a[15:0])) * 33'($signed(source_b[15:0])));

    sequence op_run_s;
        (state == NHMAC_IDLE && start) ##1 (state == NHMAC_CALC) ##1 (state == NHMAC_WRITE);
    endsequence
    sequence op_done_s;
        ##1 (state == NHMAC_IDLE) && done;
    endsequence

    op_flow_a: assert property (op_run_s |-> op_done_s)
        else $error("operation did not finish in three cycles");
    hi_product_a: assert property (state == NHMAC_CALC && !op_low |=> inter == $past(exp_hi))
        else $error("high halfword intermediate wrong");
    lo_product_a: assert property (state == NHMAC_CALC && op_low |=> inter == $past(exp_lo))
        else $error("low halfword intermediate wrong");
    modulo_wb_a: assert property (state == NHMAC_WRITE && !op_sat |=> dest == $past(inter[31:0]))
        else $error("modulo writeback wrong");
    sat_fit_a: assert property (state == NHMAC_WRITE && op_sat && !(inter[32] ^ inter[31])
        |=> dest == $past(inter[31:0]))
        else $error("saturating writeback without overflow wrong");
    sat_clamp_a: assert property (state == NHMAC_WRITE && op_sat && (inter[32] ^ inter[31])
        |=> dest == ($past(inter[32]) ? 32'h8000_0000 : 32'h7FFF_FFFF))
        else $error("saturation clamp wrong");
    no_flags_a: assert property (state == NHMAC_WRITE && !op_rec && !op_ove
        |=> $stable(fixed_point_exception_reg) && $stable(condition_field_zero))
        else $error("flags changed without record or overflow enable");
    rec_only_a: assert property (state == NHMAC_WRITE && op_rec && !op_ove
        |=> $stable(fixed_point_exception_reg)
            && condition_field_zero[3:1] == {dest[31], !dest[31] && dest != 32'h0, dest == 32'h0})
        else $error("record-only update wrong");
    ove_only_a: assert property (state == NHMAC_WRITE && op_ove && !op_rec
        |=> $stable(condition_field_zero)
            && fixed_point_exception_reg[30] == $past(inter[32] ^ inter[31]))
        else $error("overflow-only update wrong");
    both_upd_a: assert property (state == NHMAC_WRITE && op_ove && op_rec
        |=> fixed_point_exception_reg[31] == ($past(fixed_point_exception_reg[31])
                                              | $past(inter[32] ^ inter[31]))
            && condition_field_zero[1] == (dest == 32'h0))
        else $error("combined flag update wrong");
    cr_summary_a: assert property (state == NHMAC_WRITE && op_rec
        |=> condition_field_zero[0] == fixed_point_exception_reg[31])
        else $error("summary copy into condition field wrong");

endmodule : nhmac_unit

//--- test/nhmac_bus_model.sv
// Purpose: AXI4-Lite master standing in for the core's decode side
// Assumes: Full word strobes; one write and one read at most in flight
// Notes:   Waits without limit; the bench watchdog ends a hang
`timescale 1ns/100ps
`include "nhmac_regs.svh"
module nhmac_bus_model (
    input  wire logic                    clk_i,
    output logic [`NHMAC_ADDR_W-1:0]     awaddr_o,
    output logic                         awvalid_o,
    input  wire logic                    awready_i,
    output nhmac_pkg::nhmac_word_t       wdata_o,
    output logic [3:0]                   wstrb_o,
    output logic                         wvalid_o,
    input  wire logic                    wready_i,
    input  wire logic [1:0]              bresp_i,
    input  wire logic                    bvalid_i,
    output logic                         bready_o,
    output logic [`NHMAC_ADDR_W-1:0]     araddr_o,
    output logic                         arvalid_o,
    input  wire logic                    arready_i,
    input  wire nhmac_pkg::nhmac_word_t  rdata_i,
    input  wire logic [1:0]              rresp_i,
    input  wire logic                    rvalid_i,
    output logic                         rready_o
);
    import nhmac_pkg::*;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
        {bready_o, araddr_o, arvalid_o, rready_o} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [`NHMAC_ADDR_W-1:0] a, input nhmac_word_t d,
                      output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        @(posedge clk_i);
        awaddr_o  <= a;
        awvalid_o <= 1'b1;
        wdata_o   <= d;
        wstrb_o   <= 4'hF;
        wvalid_o  <= 1'b1;
        bready_o  <= 1'b1;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_i);
            if (!aw_ok && awready_i) begin
                aw_ok = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o  <= ~a;
            end
            if (!w_ok && wready_i) begin
                w_ok = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o  <= ~d;
            end
        end
        do @(posedge clk_i); while (bvalid_i !== 1'b1);
        resp = bresp_i;
        bready_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [`NHMAC_ADDR_W-1:0] a, output nhmac_word_t d,
                      output logic [1:0] resp);
        @(posedge clk_i);
        araddr_o  <= a;
        arvalid_o <= 1'b1;
        rready_o  <= 1'b1;
        do @(posedge clk_i); while (arready_i !== 1'b1);
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
        do @(posedge clk_i); while (rvalid_i !== 1'b1);
        d    = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
    endtask : rd
endmodule : nhmac_bus_model

//--- test/testbench.sv
// Purpose: Self-checking bench of the negative MAC unit over all variants
// Assumes: Start is polled through the status done bit
// Notes:   Corner operands force both saturation directions and a zero result
`timescale 1ns/100ps
`include "nhmac_regs.svh"
module testbench;
    import nhmac_pkg::*;
    logic                       ref_clk_i;
    logic                       sys_rst_i;
    logic [`NHMAC_ADDR_W-1:0]   awaddr, araddr;
    logic                       awvalid, awready, wvalid, wready, bvalid, bready;
    logic                       arvalid, arready, rvalid, rready;
    logic [3:0]                 wstrb;
    logic [1:0]                 bresp, rresp, r;
    nhmac_word_t                wdata, rdata, q, a, b, d, fx, cr, ed, efx, ecr, seed;
    integer                     error_cnt, n_tests, i, k;
    nhmac_unit nhmac_unit_i (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    nhmac_bus_model nhmac_bus_model_i (
        .clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready));
    ////////////////////////////////////////////////////////////////////////////
    function automatic nhmac_word_t xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // v: bit0 low halfword, bit1 saturate, bit2 record, bit3 overflow enable
    function automatic void model(input nhmac_word_t a, b, d, fx, cr, input logic [3:0] v,
                                  output nhmac_word_t d_o, fx_o, cr_o);
        logic signed [15:0] ha;
        logic signed [15:0] hb;
        logic signed [31:0] p;
        nhmac_wide_t        w;
        logic               ovf;
        ha = v[0] ? a[15:0] : a[31:16];
        hb = v[0] ? b[15:0] : b[31:16];
        p  = ha * hb;
        w  = {d[31], d} - {p[31], p};
        ovf = w[32] ^ w[31];
        d_o = (v[1] && ovf) ? (w[32] ? `NHMAC_SAT_MIN : `NHMAC_SAT_MAX) : w[31:0];
        fx_o = fx;
        if (v[3]) begin
            fx_o[`NHMAC_FX_EXCESS]  = ovf;
            fx_o[`NHMAC_FX_SUMMARY] = fx[`NHMAC_FX_SUMMARY] | ovf;
        end
        cr_o = cr;
        if (v[2]) begin
            cr_o = {28'h0, d_o[31], !d_o[31] && d_o != 0, d_o == 0, fx_o[31]};
        end
    endfunction : model
    task automatic check(input nhmac_word_t got, input nhmac_word_t exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Whole run needs a few thousand cycles; the margin covers slow answers
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        sys_rst_i = 1'b1;
        error_cnt = 0;
        n_tests   = 0;
        seed      = 32'hEC98;
        fx        = '0;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i <= 24; i += 4) begin
            nhmac_bus_model_i.rd(i[4:0], q, r);
            check(q, `NHMAC_RST_WORD);
        end
        nhmac_bus_model_i.rd(5'h1C, q, r);
        check({30'h0, r}, {30'h0, `NHMAC_RESP_SLVERR});
        check(q, 32'h0);
        nhmac_bus_model_i.wr(5'h1C, xs(), r);
        check({30'h0, r}, {30'h0, `NHMAC_RESP_SLVERR});
        for (i = 0; i < 64; i++) begin
            case (i[5:4])
                2'h0: begin
                    a = 32'h8000_8000;
                    b = 32'h7FFF_7FFF;
                    d = `NHMAC_SAT_MAX;
                end
                2'h1: begin
                    a = 32'h8000_8000;
                    b = 32'h8000_8000;
                    d = `NHMAC_SAT_MIN;
                end
                2'h2: begin
                    a = xs();
                    b = 32'h0;
                    d = 32'h0;
                end
                default: begin
                    a = xs();
                    b = xs();
                    d = xs();
                end
            endcase
            nhmac_bus_model_i.wr(`NHMAC_OFF_SRC_A, a, r);
            nhmac_bus_model_i.wr(`NHMAC_OFF_SRC_B, b, r);
            nhmac_bus_model_i.wr(`NHMAC_OFF_DEST, d, r);
            // Odd passes keep the flags of the previous run to test stickiness
            if (!i[0]) begin
                fx = xs() & 32'h3FFF_FFFF;
                nhmac_bus_model_i.wr(`NHMAC_OFF_FXEXC, fx, r);
            end
            cr = xs() & 32'h0000_000F;
            nhmac_bus_model_i.wr(`NHMAC_OFF_CRZ, cr, r);
            model(a, b, d, fx, cr, i[3:0], ed, efx, ecr);
            nhmac_bus_model_i.wr(`NHMAC_OFF_CTRL, {27'h0, i[3:0], 1'b1}, r);
            k = 0;
            do begin
                nhmac_bus_model_i.rd(`NHMAC_OFF_STATUS, q, r);
                k++;
            end while (q[`NHMAC_ST_DONE] !== 1'b1 && k < 20);
            check({31'h0, q[`NHMAC_ST_DONE]}, 32'h1);
            nhmac_bus_model_i.rd(`NHMAC_OFF_DEST, q, r);
            check(q, ed);
            nhmac_bus_model_i.rd(`NHMAC_OFF_FXEXC, q, r);
            check(q, efx);
            fx = efx;
            nhmac_bus_model_i.rd(`NHMAC_OFF_CRZ, q, r);
            check(q, ecr);
        end
        report_and_stop();
    end
endmodule : testbench
